// ==== etc_trace_map.svh ====
// Register offsets, field positions, reset values and crossing widths
// for the external trace output block.
// Assumes a 12-bit APB byte address and 32-bit APB data.
`ifndef ETC_TRACE_MAP_SVH
`define ETC_TRACE_MAP_SVH

`define ETC_ADDR_W        12
`define ETC_CTRL_OFF      12'h000
`define ETC_STATUS_OFF    12'h004
`define ETC_CONFIG_OFF    12'h008

`define ETC_CTRL_EN_BIT   0
`define ETC_CTRL_PAT_BIT  1
`define ETC_CTRL_BANK_LSB 8
`define ETC_CTRL_BANK_W   6
`define ETC_CTRL_RST      32'h0000_0000

`define ETC_STAT_DONE_BIT 0
`define ETC_STAT_EN_BIT   1
`define ETC_STAT_PAT_BIT  2
`define ETC_STAT_BANK_LSB 8

`define ETC_CFG_PINS_LSB  0
`define ETC_CFG_BANKS_LSB 8
`define ETC_CFG_TIME_BIT  16
`define ETC_CFG_RATE_BIT  17
`define ETC_CFG_AON_BIT   18
`define ETC_CFG_AUTO_BIT  19
`define ETC_CFG_OK_BIT    20

`define ETC_XFER_W        8
`define ETC_PIN_MIN       4
`define ETC_PIN_MAX       128
`define ETC_BANK_MAX      64

`endif

// ==== etc_trace_pkg.sv ====
// Types shared by the external trace output block.
// Assumes etc_trace_map.svh is compiled alongside.
package etc_trace_pkg;

    typedef enum logic [1:0] {
        ETC_ACQ_STATE  = 2'b01,
        ETC_ACQ_TIMING = 2'b10
    } etc_acq_t;

    typedef struct packed {
        logic       en;
        logic       pattern;
        logic [5:0] bank;
    } etc_ctrl_t;

endpackage

// ==== etc_word_xfer.sv ====
// Toggle handshake that carries one word from one clock domain to another.
// Assumes the source holds no new launch while busy is high.
`timescale 1ns/100ps
module etc_word_xfer #(
    parameter int W = 8
) (
    // Source domain
    input  wire logic         src_clk,
    input  wire logic         src_rst_n,
    input  wire logic         src_launch,
    input  wire logic [W-1:0] src_data,
    output logic              src_busy,
    // Destination domain
    input  wire logic         dst_clk,
    input  wire logic         dst_rst_n,
    output logic [W-1:0]      dst_data,
    output logic              dst_pulse
);

    logic [W-1:0] hold_q;
    logic         req_q;
    logic         ack_s1_q;
    logic         ack_s2_q;
    logic         req_s1_q;
    logic         req_s2_q;
    logic         req_s3_q;

    ////////////////////////////////////////////////////////////////////////
    // Hold word steady until the far side has echoed the toggle;
    // echo comes from the third stage, after the capture edge, so a
    // new launch can never move the word while it is being taken
    always_ff @(posedge src_clk or negedge src_rst_n) begin
        if (!src_rst_n) begin
            hold_q   <= '0;
            req_q    <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= req_s3_q;
            ack_s2_q <= ack_s1_q;
            if (src_launch && !src_busy) begin
                hold_q <= src_data;
                req_q  <= ~req_q;
            end
        end
    end

    assign src_busy = req_q ^ ack_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Word is stable by the time the synchronised toggle arrives
    always_ff @(posedge dst_clk or negedge dst_rst_n) begin
        if (!dst_rst_n) begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            req_s3_q  <= 1'b0;
            dst_data  <= '0;
            dst_pulse <= 1'b0;
        end else begin
            req_s1_q  <= req_q;
            req_s2_q  <= req_s1_q;
            req_s3_q  <= req_s2_q;
            dst_pulse <= req_s2_q ^ req_s3_q;
            if (req_s2_q ^ req_s3_q) begin
                dst_data <= hold_q;
            end
        end
    end

endmodule

// ==== etc_trace_top.sv ====
// External trace output block: APB control, bank select, pin drivers.
// Assumes bank_data is tied to zero where unused and, in state mode,
// driven from core_clk; the pins go straight to a probe connector.
//
// Function
// - State mode: registered path on core clock
// - Timing mode: combinational path to pins
// - Clock pin: sampling clock or extra data
// - Pins run at 1x or 2x input rate
// - 2x only allowed in state mode
// - No sample storage, direct forwarding
// - Pin count parameter, 4 through 128
// - Runtime bank mux, 1 to 64 banks, power of two only
// - Bank width from mode and rate
// - Always-on keeps logic and drivers enabled
// - Always-on selects bank 0 from start
// - Always-on default off, timing mode only
// - Auto setup pattern for pin discovery
`timescale 1ns/100ps
`include "etc_trace_map.svh"
module etc_trace_top #(
    parameter etc_trace_pkg::etc_acq_t ACQ_MODE = etc_trace_pkg::ETC_ACQ_STATE,
    parameter int TDM_RATE   = 1,
    parameter int PIN_COUNT  = 8,
    parameter int BANK_COUNT = 4,
    parameter bit ALWAYS_ON  = 1'b0,
    parameter bit AUTO_SETUP = 1'b1,
    localparam bit IS_TIMING = (ACQ_MODE == etc_trace_pkg::ETC_ACQ_TIMING),
    localparam int RATE      = (!IS_TIMING && TDM_RATE == 2) ? 2 : 1,
    localparam int BANK_W    = IS_TIMING ? PIN_COUNT + 1 : PIN_COUNT * RATE
) (
    // APB slave
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [`ETC_ADDR_W-1:0]       paddr,
    input  wire logic [31:0]                  pwdata,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Core clock and signal banks
    input  wire logic                         core_clk,
    input  wire logic [BANK_COUNT*BANK_W-1:0] bank_data,
    // Probe pins
    output logic                              trace_clock_out,
    output logic [PIN_COUNT-1:0]              trace_data_out,
    output logic                              trace_out_en
);

    ////////////////////////////////////////////////////////////////////////
    // Build-time checks and derived sizes

    localparam bit AON_EFF  = ALWAYS_ON && IS_TIMING;
    localparam bit PINS_OK  = (PIN_COUNT >= `ETC_PIN_MIN) &&
                              (PIN_COUNT <= `ETC_PIN_MAX);
    localparam bit BANKS_OK = (BANK_COUNT >= 1) &&
                              (BANK_COUNT <= `ETC_BANK_MAX) &&
                              ((BANK_COUNT & (BANK_COUNT - 1)) == 0);
    localparam bit CFG_OK   = PINS_OK && BANKS_OK;
    localparam int SEL_W    = (BANK_COUNT > 1) ? $clog2(BANK_COUNT) : 1;
    localparam int PTR_W    = $clog2(`ETC_PIN_MAX);

    // Reset image of the applied control word: bank 0, enabled if always-on
    localparam logic [`ETC_XFER_W-1:0] CTRL_BOOT =
        {AON_EFF, 1'b0, `ETC_CTRL_BANK_W'(0)};

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [31:0]               prdata_q;
    logic                      pready_q;
    logic                      pslverr_q;
    etc_trace_pkg::etc_ctrl_t  ctrl_q;
    etc_trace_pkg::etc_ctrl_t  sent_q;
    logic                      xfer_busy;

    wire hit_ctrl   = (paddr == `ETC_CTRL_OFF);
    wire hit_status = (paddr == `ETC_STATUS_OFF);
    wire hit_config = (paddr == `ETC_CONFIG_OFF);
    wire hit_any    = hit_ctrl || hit_status || hit_config;

    // First access cycle raises pready; the next edge completes the transfer
    wire acc_start  = psel && penable && !pready_q;
    wire acc_done   = psel && penable && pready_q;
    wire ctrl_wr    = acc_done && pwrite && hit_ctrl;

    // Effective control word: forced enable and blocked pattern per build
    etc_trace_pkg::etc_ctrl_t ctrl_eff;
    assign ctrl_eff = {ctrl_q.en || AON_EFF,
                       ctrl_q.pattern && AUTO_SETUP,
                       ctrl_q.bank};

    wire settled = (sent_q == ctrl_eff) && !xfer_busy;

    wire [31:0] ctrl_word =
        {16'h0000,
         2'b00, ctrl_q.bank,
         6'h00, ctrl_q.pattern, ctrl_q.en};

    wire [31:0] status_word =
        {16'h0000,
         2'b00, sent_q.bank,
         5'h00, sent_q.pattern, sent_q.en, settled};

    wire [31:0] config_word =
        {11'h000,
         CFG_OK, AUTO_SETUP, AON_EFF, (RATE == 2), IS_TIMING,
         8'(BANK_COUNT),
         8'(PIN_COUNT)};

    wire [31:0] rd_word =
        hit_ctrl   ? ctrl_word   :
        hit_status ? status_word :
        hit_config ? config_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= acc_start;
            pslverr_q <= acc_start && !hit_any;
            prdata_q  <= (acc_start && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // Control register, replaces the debug controller control port
    // Writes to status, config or unmapped offsets change nothing

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= etc_trace_pkg::etc_ctrl_t'(`ETC_XFER_W'(`ETC_CTRL_RST));
        end else if (ctrl_wr) begin
            ctrl_q.en      <= pwdata[`ETC_CTRL_EN_BIT];
            ctrl_q.pattern <= pwdata[`ETC_CTRL_PAT_BIT];
            ctrl_q.bank    <= pwdata[`ETC_CTRL_BANK_LSB +: `ETC_CTRL_BANK_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Carry the control word into the core clock domain

    logic                      core_rst_s1_q;
    logic                      core_rst_n_q;
    logic [`ETC_XFER_W-1:0]    xfer_word;
    logic                      xfer_pulse;
    etc_trace_pkg::etc_ctrl_t  act_q;

    // Launch once no transfer is busy if the effective word differs from the last send
    wire xfer_launch = (sent_q != ctrl_eff) && !xfer_busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sent_q <= etc_trace_pkg::etc_ctrl_t'(CTRL_BOOT);
        end else if (xfer_launch) begin
            sent_q <= ctrl_eff;
        end
    end

    // Core-side reset: asserts at once, releases on core_clk
    always_ff @(posedge core_clk or negedge presetn) begin
        if (!presetn) begin
            core_rst_s1_q <= 1'b0;
            core_rst_n_q  <= 1'b0;
        end else begin
            core_rst_s1_q <= 1'b1;
            core_rst_n_q  <= core_rst_s1_q;
        end
    end

    etc_word_xfer #(
        .W (`ETC_XFER_W)
    ) u_ctrl_xfer (
        .src_clk    (pclk),
        .src_rst_n  (presetn),
        .src_launch (xfer_launch),
        .src_data   (ctrl_eff),
        .src_busy   (xfer_busy),
        .dst_clk    (core_clk),
        .dst_rst_n  (core_rst_n_q),
        .dst_data   (xfer_word),
        .dst_pulse  (xfer_pulse)
    );

    // Applied word starts at bank 0 so traffic flows right after start-up in an always-on build
    always_ff @(posedge core_clk or negedge core_rst_n_q) begin
        if (!core_rst_n_q) begin
            act_q <= etc_trace_pkg::etc_ctrl_t'(CTRL_BOOT);
        end else if (xfer_pulse) begin
            act_q <= etc_trace_pkg::etc_ctrl_t'(xfer_word);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bank multiplexer; banks are sized from mode and rate

    wire [SEL_W-1:0]  bank_sel  =
        (BANK_COUNT > 1) ? act_q.bank[SEL_W-1:0] : '0;
    wire [BANK_W-1:0] bank_word =
        bank_data[int'(bank_sel) * BANK_W +: BANK_W];

    wire drive_on = act_q.en && CFG_OK;
    wire pat_on   = drive_on && act_q.pattern;

    logic out_en_q;

    always_ff @(posedge core_clk or negedge core_rst_n_q) begin
        if (!core_rst_n_q) begin
            out_en_q <= AON_EFF && CFG_OK;
        end else begin
            out_en_q <= drive_on;
        end
    end

    assign trace_out_en = out_en_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin discovery pattern: one walking high bit across the data pins
    // so the analyzer can map pins to pods and sweep its sample phase

    logic [PTR_W-1:0]     walk_q;
    logic [PIN_COUNT-1:0] pat_word;

    always_ff @(posedge core_clk or negedge core_rst_n_q) begin
        if (!core_rst_n_q) begin
            walk_q <= '0;
        end else if (!pat_on || walk_q == PTR_W'(PIN_COUNT - 1)) begin
            walk_q <= '0;
        end else begin
            walk_q <= walk_q + PTR_W'(1);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pat
            assign pat_word[gi] = pat_on && (walk_q == PTR_W'(gi));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers; nothing is stored beyond the pipeline stages

    generate
        if (IS_TIMING) begin : g_timing
            // No flops on the data path: the pins follow the inputs
            assign trace_data_out =
                !drive_on ? '0 :
                pat_on    ? pat_word :
                            bank_word[PIN_COUNT-1:0];
            // Clock pin carries the extra bank bit
            assign trace_clock_out =
                drive_on && !pat_on && bank_word[PIN_COUNT];
        end else begin : g_state
            logic [BANK_W-1:0]    cap_q;
            logic [PIN_COUNT-1:0] lo_q;
            logic [PIN_COUNT-1:0] hi_q;
            logic [PIN_COUNT-1:0] lo_d;
            logic [PIN_COUNT-1:0] hi_d;

            // Upper half only exists at the doubled rate
            assign lo_d = !drive_on ? '0 :
                          pat_on    ? pat_word : cap_q[PIN_COUNT-1:0];
            assign hi_d = (RATE == 1) ? lo_d :
                          !drive_on ? '0 :
                          pat_on    ? pat_word :
                                      cap_q[BANK_W-1 -: PIN_COUNT];

            always_ff @(posedge core_clk or negedge core_rst_n_q) begin
                if (!core_rst_n_q) begin
                    cap_q <= '0;
                    lo_q  <= '0;
                    hi_q  <= '0;
                end else begin
                    cap_q <= bank_word;
                    lo_q  <= lo_d;
                    hi_q  <= hi_d;
                end
            end

            // High phase shows the lower half, low phase the upper;
            // at 1x both halves match so the clock select is harmless
            assign trace_data_out = core_clk ? lo_q : hi_q;

            // Inverted core clock puts its rising edge mid-word at 1x;
            // at 2x the analyzer's phase sweep places its samples
            assign trace_clock_out = out_en_q && !core_clk;
        end
    endgenerate

endmodule

// ==== etc_trace_chk.sv ====
// Port checks for the external trace output block.
// Assumes state mode; bound onto etc_trace_top at the foot of this file.
`timescale 1ns/100ps
module etc_trace_chk #(
    parameter int TDM_RATE   = 1,
    parameter int PIN_COUNT  = 8,
    parameter int BANK_COUNT = 4,
    parameter int BANK_W     = 8
) (
    // APB
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [11:0]                  paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    // Core side and pins
    input wire logic                         core_clk,
    input wire logic [BANK_COUNT*BANK_W-1:0] bank_data,
    input wire logic                         trace_clock_out,
    input wire logic [PIN_COUNT-1:0]         trace_data_out,
    input wire logic                         trace_out_en
);
    localparam logic [31:0] CFG_EXP = 32'(PIN_COUNT)
        | (32'(BANK_COUNT) << 8) | 32'h0018_0000
        | ((TDM_RATE == 2) ? 32'h0002_0000 : 32'h0000_0000);
    wire hit = (paddr == 12'h000) || (paddr == 12'h004) || (paddr == 12'h008);

    sequence acc_start;
        psel && penable && !pready;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_start |=> pready) else $error("ready not one cycle late");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready held too long");
    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("error without ready");
    rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000) else $error("stray read data");
    err_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_start |=> pslverr == !$past(hit)) else $error("wrong error");
    cfg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_start ##0 (!pwrite && paddr == 12'h008) |=> prdata == CFG_EXP)
        else $error("config word wrong");
    clk_low_a: assert property (@(posedge core_clk) disable iff (!presetn)
        trace_clock_out == trace_out_en) else $error("clock pin low phase");
    clk_high_a: assert property (@(negedge core_clk) disable iff (!presetn)
        !trace_clock_out) else $error("clock pin high phase");
    pins_off_a: assert property (@(negedge core_clk) disable iff (!presetn)
        !trace_out_en [*3] |-> trace_data_out == '0) else $error("pins live");
endmodule

bind etc_trace_top etc_trace_chk #(
    .TDM_RATE(TDM_RATE), .PIN_COUNT(PIN_COUNT),
    .BANK_COUNT(BANK_COUNT), .BANK_W(BANK_W)
) etc_trace_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_clk(core_clk),
    .bank_data(bank_data), .trace_clock_out(trace_clock_out),
    .trace_data_out(trace_data_out), .trace_out_en(trace_out_en)
);

// ==== etc_analyzer_model.sv ====
// Behavioural logic analyzer on the probe pins.
// Assumes 2x state mode: low half in the high phase of the core clock.
`timescale 1ns/100ps
module etc_analyzer_model #(
    parameter int PIN_COUNT = 8
) (
    // Pins
    input wire logic                 core_clk,
    input wire logic                 trace_clock_out,
    input wire logic [PIN_COUNT-1:0] trace_data_out,
    // Captured sample
    output logic [2*PIN_COUNT-1:0]   word,
    output logic                     clk_hi
);
    logic [PIN_COUNT-1:0] lo;
    // Mid-phase sampling stays clear of the pin switching instants
    always @(posedge core_clk) begin
        #30;
        lo = trace_data_out;
    end
    always @(negedge core_clk) begin
        #30;
        clk_hi = trace_clock_out;
        word = {trace_data_out, lo};
    end
endmodule

// ==== external_trace_output_core_bench.sv ====
// Self-checking bench for the trace block in 2x state mode.
// Assumes the analyzer model and the bound checker are compiled with it.
`timescale 1ns/100ps
module external_trace_output_core_bench;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] word;
        logic        en;
    } etc_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        core_clk, trace_clock_out, trace_out_en, clk_hi, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] bank_data;
    logic [7:0]  trace_data_out;
    logic [7:0]  acc;
    logic [15:0] word;
    int          errors, n_tests;
    etc_row_t    rows [6] = '{'{32'h0000_0001, 16'h1A2B, 1'b1},
        '{32'h0000_0101, 16'h3C4D, 1'b1}, '{32'h0000_0201, 16'h5E6F, 1'b1},
        '{32'h0000_0000, 16'h0000, 1'b0}, '{32'h0000_0301, 16'h7081, 1'b1},
        '{32'h0000_3F01, 16'h7081, 1'b1}};

    etc_trace_top #(.TDM_RATE(2), .PIN_COUNT(8), .BANK_COUNT(4))
    etc_trace_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_clk(core_clk),
        .bank_data(bank_data), .trace_clock_out(trace_clock_out),
        .trace_data_out(trace_data_out), .trace_out_en(trace_out_en));
    etc_analyzer_model #(.PIN_COUNT(8)) etc_analyzer_model_inst (
        .core_clk(core_clk), .trace_clock_out(trace_clock_out),
        .trace_data_out(trace_data_out), .word(word), .clk_hi(clk_hi));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        core_clk = 1'b0;
        #7;
        // First edge lands inside reset so the core side starts known
        core_clk = 1'b1;
        forever #62.5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        errors++;
        wrap_up();
    end

    task wrap_up();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Waits on pready as sampled at each rising edge; data taken there
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            r = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task settle(input logic [31:0] c);
        logic [31:0] x;
        int n;
        begin
            x = {18'h0, c[13:8], 5'h0, c[1], c[0], 1'b1};
            rd = 32'h0;
            for (n = 0; n < 40 && rd !== x; n++)
                apb(1'b0, 12'h004, 32'h0, rd, er);
            check(rd, x);
        end
    endtask

    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; presetn = 1'b0; errors = 0; n_tests = 0;
        bank_data = 64'h7081_5E6F_3C4D_1A2B;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, rd, er);
        check(rd, 32'h0000_0000);
        apb(1'b1, 12'h008, 32'h0, rd, er);
        apb(1'b0, 12'h008, 32'h0, rd, er);
        check(rd, 32'h001A_0408);
        apb(1'b0, 12'h00C, 32'h0, rd, er);
        check({rd[30:0], er}, 32'h0000_0001);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h000, rows[i].ctrl, rd, er);
            settle(rows[i].ctrl);
            repeat (4) @(posedge core_clk);
            check(32'(word), 32'(rows[i].word));
            check(32'(clk_hi), 32'(rows[i].en));
            check(32'(trace_out_en), 32'(rows[i].en));
            $display("test row %0d done", i);
        end
        @(posedge core_clk);
        bank_data[63:48] <= 16'h9ABC;
        repeat (4) @(posedge core_clk);
        check(32'(word), 32'h0000_9ABC);
        $display("test stream done");
        apb(1'b1, 12'h000, 32'h0000_0003, rd, er);
        settle(32'h0000_0003);
        repeat (4) @(posedge core_clk);
        acc = 8'h00;
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            check(32'($countones(word[7:0])), 32'h0000_0001);
            check(32'(word[15:8]), 32'(word[7:0]));
            acc = acc | word[7:0];
        end
        check(32'(acc), 32'h0000_00FF);
        $display("test pattern done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check({trace_data_out, trace_out_en}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, rd, er);
        check(rd, 32'h0000_0000);
        $display("test second reset done");
        wrap_up();
    end
endmodule
